/* rtl/plcell_pkg.sv */
package plcell_pkg;

  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] SEL_OFS = 8'h00;
  localparam logic [7:0] INPUT_OFS = 8'h04;
  localparam logic [7:0] ROW_BIT_OFS = 8'h08;
  localparam logic [7:0] TABLE_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // Fields of the selector register.
  localparam int CELL_SEL_POS = 0;
  localparam int TABLE_SEL_POS = 1;
  localparam int SLOT_SEL_LSB = 2;
  localparam int ROW_IDX_LSB = 4;

  // Fields of the input register.
  localparam int SRC_LSB = 0;
  localparam int MODE_LSB = 8;

  // Fields of the status register.
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_HIT_LSB = 8;

  // Sizes.
  localparam int CELLS = 2;
  localparam int SLOTS = 3;
  localparam int ROWS = 8;
  localparam int SRC_W = 5;
  localparam int MODE_W = 3;

  // Table selector values.
  localparam logic TABLE_VALUE = 1'h0;
  localparam logic TABLE_ENABLE = 1'h1;

  // Activation modes.
  localparam logic [2:0] ACTIVE_WHEN_LOW = 3'h0;
  localparam logic [2:0] ACTIVE_WHEN_HIGH = 3'h1;
  localparam logic [2:0] ON_FALL = 3'h2;
  localparam logic [2:0] ON_RISE = 3'h3;
  localparam logic [2:0] ON_EITHER_TRANSITION = 3'h4;

  // Input source codes; the code is the bit index into the source vector.
  localparam logic [4:0] SRC_ZERO = 5'h00;
  localparam logic [4:0] SRC_LINE0 = 5'h01;
  localparam logic [4:0] SRC_USER0 = 5'h05;
  localparam logic [4:0] SRC_CNT0_START = 5'h09;
  localparam logic [4:0] SRC_CNT1_START = 5'h0A;
  localparam logic [4:0] SRC_CNT0_END = 5'h0B;
  localparam logic [4:0] SRC_CNT1_END = 5'h0C;
  localparam logic [4:0] SRC_CELL0 = 5'h0D;
  localparam logic [4:0] SRC_CELL1 = 5'h0E;
  localparam logic [4:0] SRC_INTEGRATION_BEGIN = 5'h0F;
  localparam logic [4:0] SRC_INTEGRATION_FINISH = 5'h10;
  localparam logic [4:0] SRC_AWAITING_FRAME_TRIGGER = 5'h11;
  localparam logic [4:0] SRC_CAPTURE_IN_PROGRESS = 5'h12;

  // Reset values.
  localparam logic [7:0] TABLE_RST = 8'h00;
  localparam logic [4:0] SRC_RST = 5'h00;
  localparam logic [2:0] MODE_RST = 3'h0;

endpackage : plcell_pkg

/* rtl/plcell_qual_if.sv */
`timescale 1ns/10ps

interface plcell_qual_if;
  logic [4:0] source;
  logic [2:0] mode;
  logic hit;

  modport cfg (output source, output mode, input hit);
  modport qual (input source, input mode, output hit);
endinterface : plcell_qual_if

/* rtl/plcell_qual.sv */
`timescale 1ns/10ps

module plcell_qual (
  input logic clk,
  input logic rst_b,
  input logic [31:0] sig_vec,
  plcell_qual_if.qual bus
);

  logic sig;
  logic prev_q;

  assign sig = sig_vec[bus.source];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      prev_q <= 1'h0;
    else
      prev_q <= sig;
  end

  // Edges compare against the previous sample of the selected signal, so a change of
  // source can itself look like one edge.
  always_comb
  begin
    unique case (bus.mode)
      plcell_pkg::ACTIVE_WHEN_LOW: bus.hit = !sig;
      plcell_pkg::ACTIVE_WHEN_HIGH: bus.hit = sig;
      plcell_pkg::ON_FALL: bus.hit = prev_q && !sig;
      plcell_pkg::ON_RISE: bus.hit = !prev_q && sig;
      plcell_pkg::ON_EITHER_TRANSITION: bus.hit = prev_q ^ sig;
      default: bus.hit = 1'h0;
    endcase
  end

  rise_pulse_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (bus.mode == plcell_pkg::ON_RISE && bus.hit && $stable(bus.mode)
      && $stable(bus.source)) ##1 ($stable(bus.mode) && $stable(bus.source))
      |-> !bus.hit)
    else $error("rising edge hit lasted more than one cycle");

  level_follow_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    bus.mode == plcell_pkg::ACTIVE_WHEN_LOW |-> bus.hit == !sig_vec[bus.source])
    else $error("low level mode does not follow the inverted source");

endmodule : plcell_qual

/* rtl/plcell_top.sv */
`timescale 1ns/10ps

module plcell_top (
  input logic clk,
  input logic rst_b,
  input logic wb_cyc_i,
  input logic wb_stb_i,
  input logic wb_we_i,
  input logic [7:0] wb_adr_i,
  input logic [3:0] wb_sel_i,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input logic [3:0] line_in,
  input logic [3:0] user_out,
  input logic [1:0] counter_start,
  input logic [1:0] counter_end,
  input logic integration_begin,
  input logic integration_finish,
  input logic awaiting_frame_trigger,
  input logic capture_in_progress,
  output logic [1:0] cell_out
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Storage.

  logic cell_select_q;
  logic table_select_q;
  logic [1:0] input_slot_select_q;
  logic [2:0] truth_row_index_q;
  logic [1:0][7:0] val_tab_q;
  logic [1:0][7:0] en_tab_q;
  logic [1:0][2:0][4:0] src_q;
  logic [1:0][2:0][2:0] mode_q;
  logic [1:0] cell_q;
  logic [1:0][2:0] hit;
  logic [1:0] val_bit;
  logic [1:0] en_bit;
  logic [31:0] sig_vec;
  logic ack_q;
  logic [31:0] rd_data_q;
  logic [31:0] rd_data_d;
  logic req_new;
  logic wr_fire;
  logic slot_ok;
  logic [7:0] tab_sel_word;

  assign cell_out = cell_q;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_data_q;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Source vector; unused codes read as zero.

  always_comb
  begin
    sig_vec = 32'h00000000;
    sig_vec[plcell_pkg::SRC_ZERO] = 1'h0;
    sig_vec[plcell_pkg::SRC_LINE0 +: 4] = line_in;
    sig_vec[plcell_pkg::SRC_USER0 +: 4] = user_out;
    sig_vec[plcell_pkg::SRC_CNT0_START] = counter_start[0];
    sig_vec[plcell_pkg::SRC_CNT1_START] = counter_start[1];
    sig_vec[plcell_pkg::SRC_CNT0_END] = counter_end[0];
    sig_vec[plcell_pkg::SRC_CNT1_END] = counter_end[1];
    sig_vec[plcell_pkg::SRC_CELL0] = cell_q[0];
    sig_vec[plcell_pkg::SRC_CELL1] = cell_q[1];
    sig_vec[plcell_pkg::SRC_INTEGRATION_BEGIN] = integration_begin;
    sig_vec[plcell_pkg::SRC_INTEGRATION_FINISH] = integration_finish;
    sig_vec[plcell_pkg::SRC_AWAITING_FRAME_TRIGGER] = awaiting_frame_trigger;
    sig_vec[plcell_pkg::SRC_CAPTURE_IN_PROGRESS] = capture_in_progress;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Cells: qualifiers, tables and output flip-flop.

  // Cell outputs enter the source vector only from the flip-flop, so feedback through a
  // cell's own output cannot form a combinational loop.
  for (genvar c = 0; c < plcell_pkg::CELLS; c++)
  begin : g_cell
    for (genvar s = 0; s < plcell_pkg::SLOTS; s++)
    begin : g_slot
      plcell_qual_if qif ();

      assign qif.source = src_q[c][s];
      assign qif.mode = mode_q[c][s];
      assign hit[c][s] = qif.hit;

      plcell_qual u_qual (
        .clk(clk),
        .rst_b(rst_b),
        .sig_vec(sig_vec),
        .bus(qif)
      );
    end

    assign val_bit[c] = val_tab_q[c][hit[c]];
    assign en_bit[c] = en_tab_q[c][hit[c]];

    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
        cell_q[c] <= 1'h0;
      else if (en_bit[c])
        cell_q[c] <= val_bit[c];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack for one cycle, writes land on the ack edge.

  assign req_new = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign slot_ok = input_slot_select_q < 2'(plcell_pkg::SLOTS);
  assign tab_sel_word = (table_select_q == plcell_pkg::TABLE_ENABLE) ?
    en_tab_q[cell_select_q] : val_tab_q[cell_select_q];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ack_q <= 1'h0;
    else
      ack_q <= req_new;
  end

  always_comb
  begin
    rd_data_d = 32'h00000000;
    unique case (wb_adr_i)
      plcell_pkg::SEL_OFS:
      begin
        rd_data_d[plcell_pkg::CELL_SEL_POS] = cell_select_q;
        rd_data_d[plcell_pkg::TABLE_SEL_POS] = table_select_q;
        rd_data_d[plcell_pkg::SLOT_SEL_LSB +: 2] = input_slot_select_q;
        rd_data_d[plcell_pkg::ROW_IDX_LSB +: 3] = truth_row_index_q;
      end
      plcell_pkg::INPUT_OFS:
      begin
        if (slot_ok)
        begin
          rd_data_d[plcell_pkg::SRC_LSB +: 5] = src_q[cell_select_q][input_slot_select_q];
          rd_data_d[plcell_pkg::MODE_LSB +: 3] = mode_q[cell_select_q][input_slot_select_q];
        end
      end
      plcell_pkg::ROW_BIT_OFS:
        rd_data_d[0] = tab_sel_word[truth_row_index_q];
      plcell_pkg::TABLE_OFS:
        rd_data_d[7:0] = tab_sel_word;
      plcell_pkg::STATUS_OFS:
      begin
        rd_data_d[plcell_pkg::STAT_OUT_LSB +: 2] = cell_q;
        rd_data_d[plcell_pkg::STAT_HIT_LSB +: 6] = hit;
      end
      default: rd_data_d = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data_q <= 32'h00000000;
    else if (req_new && !wb_we_i)
      rd_data_q <= rd_data_d;
    else
      rd_data_q <= 32'h00000000;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Selectors.

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cell_select_q <= 1'h0;
      table_select_q <= plcell_pkg::TABLE_VALUE;
      input_slot_select_q <= 2'h0;
      truth_row_index_q <= 3'h0;
    end
    else if (wr_fire && wb_adr_i == plcell_pkg::SEL_OFS && wb_sel_i[0])
    begin
      cell_select_q <= wb_dat_i[plcell_pkg::CELL_SEL_POS];
      table_select_q <= wb_dat_i[plcell_pkg::TABLE_SEL_POS];
      input_slot_select_q <= wb_dat_i[plcell_pkg::SLOT_SEL_LSB +: 2];
      truth_row_index_q <= wb_dat_i[plcell_pkg::ROW_IDX_LSB +: 3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Input settings, shared by both tables of the selected cell.

  // Slot 3 is a selector value with no table input behind it; writes to it are dropped.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      src_q <= '0;
    else if (wr_fire && wb_adr_i == plcell_pkg::INPUT_OFS && wb_sel_i[0] && slot_ok)
      src_q[cell_select_q][input_slot_select_q] <= wb_dat_i[plcell_pkg::SRC_LSB +: 5];
  end

  // Activation codes above the last mode are refused so a slot never sits in a dead mode.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_q <= '0;
    else if (wr_fire && wb_adr_i == plcell_pkg::INPUT_OFS && wb_sel_i[1] && slot_ok
             && wb_dat_i[plcell_pkg::MODE_LSB +: 3] <= plcell_pkg::ON_EITHER_TRANSITION)
      mode_q[cell_select_q][input_slot_select_q] <= wb_dat_i[plcell_pkg::MODE_LSB +: 3];
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Truth tables.

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      val_tab_q <= {plcell_pkg::TABLE_RST, plcell_pkg::TABLE_RST};
    else if (wr_fire && table_select_q == plcell_pkg::TABLE_VALUE && wb_sel_i[0])
    begin
      if (wb_adr_i == plcell_pkg::TABLE_OFS)
        val_tab_q[cell_select_q] <= wb_dat_i[7:0];
      else if (wb_adr_i == plcell_pkg::ROW_BIT_OFS)
        val_tab_q[cell_select_q][truth_row_index_q] <= wb_dat_i[0];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      en_tab_q <= {plcell_pkg::TABLE_RST, plcell_pkg::TABLE_RST};
    else if (wr_fire && table_select_q == plcell_pkg::TABLE_ENABLE && wb_sel_i[0])
    begin
      if (wb_adr_i == plcell_pkg::TABLE_OFS)
        en_tab_q[cell_select_q] <= wb_dat_i[7:0];
      else if (wb_adr_i == plcell_pkg::ROW_BIT_OFS)
        en_tab_q[cell_select_q][truth_row_index_q] <= wb_dat_i[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Checks.

  ack_pulse_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack stayed high for more than one cycle");

  ack_reply_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not acknowledged on the next cycle");

  cell_hold_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !en_bit[0] |=> $stable(cell_out[0]))
    else $error("cell 0 output changed while its enable table gave zero");

  cell_load_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    en_bit[1] |=> cell_out[1] == $past(val_bit[1]))
    else $error("cell 1 output did not load the value table");

  row_order_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    val_bit[0] == val_tab_q[0][{g_cell[0].g_slot[2].qif.hit, g_cell[0].g_slot[1].qif.hit,
      g_cell[0].g_slot[0].qif.hit}])
    else $error("value table row not formed with input 2 on top");

  pass_through_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    en_tab_q[0] == 8'hFF ##1 en_tab_q[0] == 8'hFF |-> cell_out[0] == $past(val_bit[0]))
    else $error("all-ones enable table did not pass the value table through");

  word_write_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_fire && wb_adr_i == plcell_pkg::TABLE_OFS && wb_sel_i[0]
      && table_select_q == plcell_pkg::TABLE_ENABLE)
    |=> en_tab_q[$past(cell_select_q)] == $past(wb_dat_i[7:0]))
    else $error("whole table write did not reach the enable table");

  row_write_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_fire && wb_adr_i == plcell_pkg::ROW_BIT_OFS && wb_sel_i[0]
      && table_select_q == plcell_pkg::TABLE_VALUE)
    |=> $stable(en_tab_q) && val_tab_q[$past(cell_select_q)][$past(truth_row_index_q)]
        == $past(wb_dat_i[0]))
    else $error("row write missed the value table or touched the enable table");

  shared_input_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_fire && wb_adr_i == plcell_pkg::INPUT_OFS && wb_sel_i[0] && slot_ok)
    |=> src_q[$past(cell_select_q)][$past(input_slot_select_q)]
        == $past(wb_dat_i[plcell_pkg::SRC_LSB +: 5]))
    else $error("input source write did not land independent of the table selector");

  idle_low_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (en_tab_q[1] == 8'h00 && !cell_out[1]) |=> !cell_out[1])
    else $error("unconfigured cell 1 output rose");

  // Read data is zero between answers so a stale word never lingers on the bus.
  read_idle_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    !wb_ack_o |-> wb_dat_o == 32'h00000000)
    else $error("read data not zero outside an acknowledge");

  mode_refuse_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_fire && wb_adr_i == plcell_pkg::INPUT_OFS
      && wb_dat_i[plcell_pkg::MODE_LSB +: 3] > plcell_pkg::ON_EITHER_TRANSITION)
    |=> $stable(mode_q))
    else $error("activation code outside the five modes was stored");

  slot_drop_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_fire && wb_adr_i == plcell_pkg::INPUT_OFS && !slot_ok)
    |=> $stable(src_q) && $stable(mode_q))
    else $error("write to the spare input slot changed a setting");

  cell_apart_a: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_fire && wb_adr_i == plcell_pkg::TABLE_OFS && !cell_select_q)
    |=> $stable(val_tab_q[1]) && $stable(en_tab_q[1]))
    else $error("table write to cell 0 changed cell 1");

endmodule : plcell_top

/* dv/testbench.sv */
`timescale 1ns/10ps

module testbench;
  logic clk;
  logic rst_b;
  logic cyc;
  logic stb;
  logic we;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] line_in;
  logic [3:0] user_out;
  logic [1:0] counter_start;
  logic [1:0] counter_end;
  logic [1:0] cell_out;
  logic integration_begin;
  logic integration_finish;
  logic awaiting_frame_trigger;
  logic capture_in_progress;
  int fails;
  int n_tests;
  int cycles;
  logic [31:0] seed;
  logic [31:0] q;
  logic [31:0] e;
  logic [31:0] cur;
  logic [31:0] prev;
  logic [7:0] tbl [2][2];
  int src [2][3];
  int md [2][3];
  int cc;
  int ct;
  int cs;
  bit chk;
  bit known [2];
  logic exp_o [2];
  logic [2:0] row;

  plcell_top plcell_top_i (
    .clk(clk),
    .rst_b(rst_b),
    .wb_cyc_i(cyc),
    .wb_stb_i(stb),
    .wb_we_i(we),
    .wb_adr_i(adr),
    .wb_sel_i(sel),
    .wb_dat_i(wdat),
    .wb_dat_o(rdat),
    .wb_ack_o(ack),
    .line_in(line_in),
    .user_out(user_out),
    .counter_start(counter_start),
    .counter_end(counter_end),
    .integration_begin(integration_begin),
    .integration_finish(integration_finish),
    .awaiting_frame_trigger(awaiting_frame_trigger),
    .capture_in_progress(capture_in_progress),
    .cell_out(cell_out)
  );

  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // Source vector in the order of the source codes; cells never feed a table here.
  function automatic logic [31:0] vec();
    return {13'h0000, capture_in_progress, awaiting_frame_trigger, integration_finish,
      integration_begin, 2'h0, counter_end, counter_start, user_out, line_in, 1'h0};
  endfunction : vec

  function automatic logic hit(input int m, input logic c, input logic p);
    case (m)
      0: return !c;
      1: return c;
      2: return p & !c;
      3: return !p & c;
      default: return p ^ c;
    endcase
  endfunction : hit

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////////
  // The request stays up until ack is seen, so a slow answer never loses data.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'h1)
      @(posedge clk);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'h0, a, 32'h0);
    check(q, exp);
  endtask : rd

  task automatic set_sel(input int c, input int t, input int s, input int r);
    cc = c;
    ct = t;
    cs = s;
    wb(1'h1, plcell_pkg::SEL_OFS, 32'(r * 16 + s * 4 + t * 2 + c));
  endtask : set_sel

  task automatic set_in(input int s, input int m);
    src[cc][cs] = s;
    md[cc][cs] = m;
    wb(1'h1, plcell_pkg::INPUT_OFS, 32'(m * 256 + s));
  endtask : set_in

  task automatic set_tbl(input logic [7:0] w);
    tbl[cc][ct] = w;
    wb(1'h1, plcell_pkg::TABLE_OFS, {24'h0, w});
  endtask : set_tbl

  task automatic drive(input logic [31:0] v);
    line_in <= v[3:0];
    user_out <= v[7:4];
    counter_start <= v[9:8];
    counter_end <= v[11:10];
    integration_begin <= v[12];
    integration_finish <= v[13];
    awaiting_frame_trigger <= v[14];
    capture_in_progress <= v[15];
  endtask : drive

  // Idle edges first, so the edge detectors forget any source switch.
  task automatic run(input int n);
    repeat (2) @(posedge clk);
    known = '{0, 0};
    chk = 1;
    repeat (n)
    begin
      drive(rnd());
      @(posedge clk);
    end
    chk = 0;
  endtask : run

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cur = vec();
    for (int c = 0; c < 2; c++)
    begin
      row = {hit(md[c][2], cur[src[c][2]], prev[src[c][2]]),
        hit(md[c][1], cur[src[c][1]], prev[src[c][1]]),
        hit(md[c][0], cur[src[c][0]], prev[src[c][0]])};
      if (chk && known[c])
        check(32'(cell_out[c]), 32'(exp_o[c]));
      if (chk && tbl[c][1][row] === 1'h1)
      begin
        exp_o[c] = tbl[c][0][row];
        known[c] = 1;
      end
    end
    prev = cur;
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      end_of_test();
    end
  end

  initial
  begin
    seed = 32'h0001_5C3A;
    rst_b = 1'h0;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    chk = 0;
    drive(32'h0);
    foreach (src[c, s])
    begin
      src[c][s] = 0;
      md[c][s] = 0;
    end
    foreach (tbl[c, t])
      tbl[c][t] = 8'h00;
    repeat (16) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    check(32'(cell_out), 32'h0);
    for (int a = 0; a < 6; a++)
      rd(8'(a * 4), (a == 4) ? 32'h0000_3F00 : 32'h0);
    set_sel(0, 0, 0, 0);
    for (int k = 0; k < 19; k++)
    begin
      set_in(k, 1);
      e = rnd();
      for (int p = 0; p < 2; p++)
      begin
        drive(p ? ~e : e);
        @(posedge clk);
        wb(1'h0, plcell_pkg::STATUS_OFS, 32'h0);
        cur = vec();
        check(q, {18'h0, 5'h1F, cur[k], 8'h00});
      end
    end
    foreach (tbl[c, t])
    begin
      set_sel(c, t, 0, 0);
      set_tbl(8'(rnd()));
    end
    foreach (tbl[c, t])
    begin
      set_sel(c, t, 0, 0);
      rd(plcell_pkg::TABLE_OFS, {24'h0, tbl[c][t]});
    end
    for (int r = 0; r < 8; r++)
    begin
      set_sel(1, 1, 0, r);
      rd(plcell_pkg::ROW_BIT_OFS, 32'(tbl[1][1][r]));
    end
    set_sel(0, 0, 0, 5);
    tbl[0][0][5] = ~tbl[0][0][5];
    wb(1'h1, plcell_pkg::ROW_BIT_OFS, 32'(tbl[0][0][5]));
    rd(plcell_pkg::TABLE_OFS, {24'h0, tbl[0][0]});
    for (int s = 0; s < 3; s++)
    begin
      set_sel(1, 0, s, 0);
      set_in(s + 5, s + 2);
    end
    foreach (src[c, s])
    begin
      set_sel(c, 1, s, 0);
      rd(plcell_pkg::INPUT_OFS, 32'(md[c][s] * 256 + src[c][s]));
    end
    set_sel(1, 0, 0, 0);
    src[1][0] = 9;
    wb(1'h1, plcell_pkg::INPUT_OFS, 32'h0000_0709);
    rd(plcell_pkg::INPUT_OFS, 32'(md[1][0] * 256 + 9));
    set_sel(1, 0, 3, 0);
    wb(1'h1, plcell_pkg::INPUT_OFS, 32'h0000_0209);
    rd(plcell_pkg::INPUT_OFS, 32'h0);
    // All-ones enable makes the cell follow the value table every cycle.
    set_sel(0, 1, 0, 0);
    set_tbl(8'hFF);
    set_sel(0, 0, 0, 0);
    set_tbl(8'(rnd()));
    for (int s = 1; s < 3; s++)
    begin
      set_sel(0, 0, s, 0);
      set_in(s + 1, 1);
    end
    set_sel(0, 0, 0, 0);
    for (int m = 0; m < 5; m++)
    begin
      set_in(1, m);
      run(40);
    end
    set_sel(0, 1, 0, 0);
    set_tbl(8'(rnd()));
    run(80);
    end_of_test();
  end
endmodule : testbench
